// *** hw/bdec_pkg.sv ***
// Package for the binary to one-hot decode datapath.
// Assumes a single 125 MHz clock domain and no software registers.
package bdec_pkg;
  localparam int BDEC_SEL_W = 4;
  localparam int BDEC_SRC_W = 8;
  localparam int BDEC_FIELD_W = 256;
  localparam int BDEC_WORD_W = 16;
  localparam logic [3:0] BDEC_N_NOP = 4'h0;
  localparam logic [3:0] BDEC_N_BIT_MAX = 4'h8;
  localparam logic [3:0] BDEC_N_WORD_MAX = 4'h4;
  localparam logic [255:0] BDEC_FIELD_RST = 256'h0;
  localparam logic [15:0] BDEC_WORD_RST = 16'h0;
  typedef enum logic {BDEC_DST_BIT, BDEC_DST_WORD} bdec_dst_t;
endpackage

// *** hw/bdec_onehot.sv ***
// One-hot generator for a field of 2^n bits at the low end of a bus.
// Purely combinational; caller qualifies n.
`timescale 1ns/1ps
module bdec_onehot
  import bdec_pkg::*;
(
  input wire logic [BDEC_SRC_W-1:0] i_value,
  input wire logic [BDEC_SEL_W-1:0] i_n,
  output logic [BDEC_FIELD_W-1:0] o_hot,
  output logic [BDEC_FIELD_W-1:0] o_span
);
  // Mask keeps only the n low source bits
  logic [BDEC_SRC_W-1:0] idx;
  genvar g;
  generate
    for (g = 0; g < BDEC_SRC_W; g++) begin : g_mask
      assign idx[g] = (g < i_n);
    end
  endgenerate
  // Decoded position; all-zero source lands on bit 0
  assign o_hot = BDEC_FIELD_W'(1) << (i_value & idx); // RQ1 RQ4 RQ6
  // Span of field bits owned by this width
  assign o_span = (BDEC_FIELD_W'(1) << (9'(1) << i_n)) - BDEC_FIELD_W'(1);
endmodule // bdec_onehot

// *** hw/bdec_core.sv ***
// Decode datapath: source value to one bit set in a bit field or a word.
// Assumes command and operands come from same-clock controller logic.
// Overview of operation
// RQ1 - Exactly one bit set in 2^n field, at position equal to source value
// RQ2 - Width zero does nothing; destination unchanged; valid widths 1 to 8
// RQ3 - Bit field destination spans up to 256 bits from first bit
// RQ4 - Bit field with zero source turns on offset zero
// RQ5 - Word destination width 1 to 4; only n low source bits used
// RQ6 - Word destination with zero source sets bit zero
// RQ7 - Word destination with width three or less clears upper bits
// RQ8 - Inactive command holds destination as left by last execution
// RQ9 - Program must reserve whole destination range for decoder alone
// RQ10 - Continuous form decodes every scan; edge form once per rising command
// RQ11 - Each execution clears all other field bits
`timescale 1ns/1ps
module bdec_core
  import bdec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_value_decode_op,
  input wire logic i_value_decode_edge_op,
  input wire bdec_dst_t i_dst,
  input wire logic [BDEC_SRC_W-1:0] i_src,
  input wire logic [BDEC_SEL_W-1:0] i_n,
  output logic [BDEC_FIELD_W-1:0] o_field,
  output logic [BDEC_WORD_W-1:0] o_word,
  output logic o_exec_state_out
);
  ////////////////////////////////////////////////////////////////////////
  // Command qualification
  logic cmd_q;
  logic [BDEC_FIELD_W-1:0] hot;
  logic [BDEC_FIELD_W-1:0] span;
  logic n_ok;
  logic edge_rise;
  logic fire;
  // Reference values for the checks; the datapath never reads them
  logic [BDEC_SRC_W-1:0] src_pos;
  logic [BDEC_FIELD_W-1:0] low_mask;

  // Legal widths depend on destination kind; shared by logic and covers
  function automatic logic width_ok(input bdec_dst_t dst, input logic [BDEC_SEL_W-1:0] n);
    if (n == BDEC_N_NOP) begin
      return 1'b0; // RQ2
    end else if (dst == BDEC_DST_BIT) begin
      return n <= BDEC_N_BIT_MAX; // RQ3
    end else begin
      return n <= BDEC_N_WORD_MAX; // RQ5
    end
  endfunction

  // Previous command level for edge form
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_q <= 1'b0;
    end else begin
      cmd_q <= i_value_decode_edge_op;
    end
  end

  // Width legality differs by destination kind; illegal widths are refused, not clamped
  assign n_ok = width_ok(i_dst, i_n); // RQ2 RQ3 RQ5
  // Edge form fires only on a low-to-high step; a command high at reset release counts
  assign edge_rise = i_value_decode_edge_op && !cmd_q; // RQ10
  // Both forms may be on together; either one runs the decode
  assign fire = n_ok && (i_value_decode_op || edge_rise); // RQ10

  bdec_onehot u_hot (
    .i_value(i_src),
    .i_n(i_n),
    .o_hot(hot),
    .o_span(span)
  );

  ////////////////////////////////////////////////////////////////////////
  // Destinations; held when not fired
  // Bit field keeps bits past 2^n so other users of the range are not disturbed
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_field <= BDEC_FIELD_RST;
    end else if (fire && i_dst == BDEC_DST_BIT) begin
      o_field <= (o_field & ~span) | hot; // RQ1 RQ11; bits past field untouched
    end // RQ8
  end

  // Word: whole word rewritten, upper bits cleared
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word <= BDEC_WORD_RST;
    end else if (fire && i_dst == BDEC_DST_WORD) begin
      o_word <= hot[BDEC_WORD_W-1:0]; // RQ6 RQ7 RQ11
    end
  end

  // Execution state follows whether the op ran this scan
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_exec_state_out <= 1'b0;
    end else begin
      o_exec_state_out <= fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Each check looks one scan after the firing edge, where the registered result stands.
  // Reference position and field mask are rebuilt here from the rules, not from the generator.
  assign src_pos = i_src & ((BDEC_SRC_W'(1) << i_n) - BDEC_SRC_W'(1));
  assign low_mask = ~({BDEC_FIELD_W{1'b1}} << (9'(1) << i_n));

  property p_word_hot;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_WORD) |=> $onehot(o_word) && o_word[$past(src_pos[3:0])];
  endproperty
  a_word_hot: assert property (p_word_hot) else $error("word not one-hot"); // RQ6

  property p_nop;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_n == BDEC_N_NOP) |=> $stable(o_field) && $stable(o_word);
  endproperty
  a_nop: assert property (p_nop) else $error("zero width changed output"); // RQ2

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!i_value_decode_op && !i_value_decode_edge_op) |=> $stable(o_field) && $stable(o_word);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while idle"); // RQ8

  property p_edge_once;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!i_value_decode_op && i_value_decode_edge_op && cmd_q) |=> !o_exec_state_out;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge form ran twice"); // RQ10

  property p_field_pos;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_BIT && i_n == 4'h8) |=> o_field[$past(i_src)] && $onehot(o_field);
  endproperty
  a_field_pos: assert property (p_field_pos) else $error("wrong bit set"); // RQ1 RQ3 RQ11

  property p_zero_src;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_BIT && i_src == 8'h00) |=> o_field[0];
  endproperty
  a_zero_src: assert property (p_zero_src) else $error("zero source missed bit 0"); // RQ4

  property p_word_upper;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_WORD && i_n <= 4'h3) |=>
      (o_word & ~$past(low_mask[BDEC_WORD_W-1:0])) == 16'h0000;
  endproperty
  a_word_upper: assert property (p_word_upper) else $error("upper word bits set"); // RQ7

  property p_word_range;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_value_decode_op && i_dst == BDEC_DST_WORD && i_n > 4'h4) |=> !o_exec_state_out;
  endproperty
  a_word_range: assert property (p_word_range) else $error("word width over 4 ran"); // RQ5

  property p_cont;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_value_decode_op && n_ok) [*3] |=> o_exec_state_out;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous form skipped scan"); // RQ10

  property p_both;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_value_decode_op && i_value_decode_edge_op && n_ok) |=> o_exec_state_out;
  endproperty
  a_both: assert property (p_both) else $error("both forms on but no run"); // RQ10

  property p_field_pick;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_BIT) |=> o_field[$past(src_pos)];
  endproperty
  a_field_pick: assert property (p_field_pick) else $error("field bit at source value not set"); // RQ1 RQ4

  property p_field_single;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_BIT) |=> $countones(o_field & $past(low_mask)) == 1;
  endproperty
  a_field_single: assert property (p_field_single) else $error("field holds other than one set bit"); // RQ11

  property p_field_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_BIT) |=> (o_field & ~$past(low_mask)) == $past(o_field & ~low_mask);
  endproperty
  a_field_keep: assert property (p_field_keep) else $error("field bits past the span moved"); // RQ3

  property p_bit_range;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_value_decode_op && i_dst == BDEC_DST_BIT && i_n > BDEC_N_BIT_MAX) |=> !o_exec_state_out;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit width over 8 ran"); // RQ2 RQ3

  property p_nop_exec;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_n == BDEC_N_NOP) |=> !o_exec_state_out;
  endproperty
  a_nop_exec: assert property (p_nop_exec) else $error("zero width reported a run"); // RQ2

  property p_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    !fire |=> $stable(o_field) && $stable(o_word);
  endproperty
  a_idle: assert property (p_idle) else $error("output moved without a run"); // RQ8

  property p_word_apart;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_BIT) |=> $stable(o_word);
  endproperty
  a_word_apart: assert property (p_word_apart) else $error("bit field run moved the word"); // RQ8

  property p_field_apart;
    @(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_dst == BDEC_DST_WORD) |=> $stable(o_field);
  endproperty
  a_field_apart: assert property (p_field_apart) else $error("word run moved the field"); // RQ8

  c_bit: cover property (@(posedge i_clk) fire && i_dst == BDEC_DST_BIT && i_n == 4'h8);
  c_word: cover property (@(posedge i_clk) fire && i_dst == BDEC_DST_WORD);
  c_edge: cover property (@(posedge i_clk) i_value_decode_edge_op && !cmd_q && n_ok);
  c_both: cover property (@(posedge i_clk) i_value_decode_op && i_value_decode_edge_op && n_ok);
  c_refused: cover property (@(posedge i_clk) i_value_decode_op && !width_ok(i_dst, i_n));
endmodule // bdec_core

// *** bench/bdec_tb.sv ***
// Self-checking bench for the decode core, one task per scenario.
// Assumes bdec_pkg compiled first; the bench drives every input at negedge.
`timescale 1ns/1ps
module testbench;
  import bdec_pkg::*;
  logic i_clk = 0, i_rst_n = 0, cont = 0, pulse = 0;
  bdec_dst_t dst = BDEC_DST_WORD;
  logic [7:0] src = 8'h00;
  logic [3:0] n = 4'h0;
  logic [255:0] field;
  logic [15:0] word;
  logic exec;
  int miscompares = 0, checks_done = 0, cnt;
  localparam logic [255:0] TOP = {1'b1, 255'h0};
  // 125 MHz clock
  always #4 i_clk = ~i_clk;
  bdec_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_value_decode_op(cont),
    .i_value_decode_edge_op(pulse), .i_dst(dst), .i_src(src), .i_n(n),
    .o_field(field), .o_word(word), .o_exec_state_out(exec));
  //////////////////////////////////////////////////////////////////////////
  // Case equality so an unknown never passes
  task chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command cycle; dropped after so a pulse sees low before next rise
  task run(input logic c, input logic p, input bdec_dst_t d, input logic [7:0] s, input logic [3:0] w);
    @(negedge i_clk);
    cont = c;
    pulse = p;
    dst = d;
    src = s;
    n = w;
    @(negedge i_clk);
    cont = 1'b0;
    pulse = 1'b0;
  endtask
  task t_word;
    run(1'b1, 1'b0, BDEC_DST_WORD, 8'h03, 4'h2);
    chk(256'(word), 256'h0008);
    chk(256'(exec), 256'h1);
    run(1'b1, 1'b0, BDEC_DST_WORD, 8'hFD, 4'h2);
    chk(256'(word), 256'h0002);
    run(1'b1, 1'b0, BDEC_DST_WORD, 8'h0F, 4'h4);
    chk(256'(word), 256'h8000);
    run(1'b1, 1'b0, BDEC_DST_WORD, 8'hFE, 4'h1);
    chk(256'(word), 256'h0001);
  endtask
  task t_hold;
    run(1'b0, 1'b0, BDEC_DST_WORD, 8'h05, 4'h3);
    chk(256'(word), 256'h0001);
    chk(256'(exec), 256'h0);
    run(1'b1, 1'b0, BDEC_DST_WORD, 8'h05, 4'h0);
    chk(256'(word), 256'h0001);
    chk(256'(exec), 256'h0);
    run(1'b1, 1'b0, BDEC_DST_WORD, 8'h01, 4'h5);
    chk(256'(word), 256'h0001);
  endtask
  // Bench owns the whole field range; nothing but the decoder writes it
  task t_field;
    run(1'b1, 1'b0, BDEC_DST_BIT, 8'hFF, 4'h8);
    chk(field, TOP);
    chk(256'(word), 256'h0001);
    run(1'b0, 1'b1, BDEC_DST_BIT, 8'h00, 4'h3);
    chk(field, TOP | 256'h1);
    run(1'b0, 1'b1, BDEC_DST_BIT, 8'h0A, 4'h4);
    chk(field, TOP | 256'h400);
    run(1'b1, 1'b0, BDEC_DST_BIT, 8'h01, 4'h9);
    chk(field, TOP | 256'h400);
    run(1'b1, 1'b1, BDEC_DST_BIT, 8'h05, 4'h1);
    chk(field, TOP | 256'h402);
    chk(256'(exec), 256'h1);
  endtask
  // Held command: pulse form fires once, continuous form every cycle
  task t_form(input logic c, input int exp);
    cnt = 0;
    @(negedge i_clk);
    cont = c;
    pulse = !c;
    dst = BDEC_DST_WORD;
    src = 8'h02;
    n = 4'h2;
    repeat (4) begin
      @(negedge i_clk);
      if (exec === 1'b1) cnt++;
    end
    cont = 1'b0;
    pulse = 1'b0;
    chk(256'(cnt), 256'(exp));
    chk(256'(word), 256'h0004);
  endtask
  // Mid-run reset with the pulse command held: it clears, then counts as a fresh rise
  task t_reset;
    @(negedge i_clk);
    pulse = 1'b1;
    dst = BDEC_DST_WORD;
    src = 8'h01;
    n = 4'h1;
    @(negedge i_clk);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    chk(field, BDEC_FIELD_RST);
    chk(256'(word), 256'(BDEC_WORD_RST));
    chk(256'(exec), 256'h0);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    chk(256'(word), 256'h0002);
    chk(256'(exec), 256'h1);
    @(negedge i_clk);
    chk(256'(exec), 256'h0);
    pulse = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is about 50 cycles; 500 cycles means a hang
  initial begin
    #4000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge i_clk);
    chk(field, BDEC_FIELD_RST);
    chk(256'(word), 256'(BDEC_WORD_RST));
    chk(256'(exec), 256'h0);
    i_rst_n = 1;
    t_word;
    t_hold;
    t_field;
    t_form(1'b0, 1);
    t_form(1'b1, 4);
    t_reset;
    wrap_up;
  end
endmodule // testbench
